// ---- hw/bit_alias_regs.svh ----
// Purpose: Address map and field constants for the bit alias translator.
// Assumes: 32-bit byte addresses, word-aligned alias accesses.
// Notes:   Operation list below.
// Operation
// (R1) Low 1 MB of SRAM, 0x20000000-0x200FFFFF, is bit addressable.
// (R2) Low 1 MB of peripherals, 0x40000000-0x400FFFFF, is bit addressable.
// (R3) SRAM alias = 0x22000000 + 32*(A-0x20000000) + 4*n.
// (R4) Peripheral alias = 0x42000000 + 32*(A-0x40000000) + 4*n.
// (R5) Each region bit maps to one alias word; only its LSB matters.
// (R6) Alias address is turned back into region address and bit first.
// (R7) Alias read fetches word, shifts chosen bit to bit 0, returns it.
// (R8) Alias write shifts LSB to bit position, changes only that bit.
// (R9) The read-modify-write of an alias write is indivisible.
// (R10) Addresses outside alias windows pass through unchanged.
`ifndef BIT_ALIAS_REGS_SVH
`define BIT_ALIAS_REGS_SVH
`define SRAM_REGION_BASE  32'h2000_0000
`define SRAM_ALIAS_BASE   32'h2200_0000
`define PERI_REGION_BASE  32'h4000_0000
`define PERI_ALIAS_BASE   32'h4200_0000
`define ALIAS_SPAN_MASK   32'hFE00_0000
`define ALIAS_OFS_MSB     24
`define ALIAS_WORD_LSB    7
`define ALIAS_BIT_LSB     2
`endif

// ---- hw/bit_alias_pkg.sv ----
package bit_alias_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } bus_rsp_t;
endpackage

// ---- hw/bit_alias_translator.sv ----
// Purpose: Turns alias-window accesses into single-bit region operations.
// Assumes: Slave answers each request with one rsp.valid pulse, any delay.
// Notes:   One access in flight; master waits for m_rsp before next request.
`timescale 1ns/1ps
`include "bit_alias_regs.svh"
module bit_alias_translator
  import bit_alias_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  // Master side
  input  wire bus_req_t m_req,
  output bus_rsp_t      m_rsp,
  output logic          m_busy,
  // Slave side
  output bus_req_t      s_req,
  output logic          s_lock,
  input  wire bus_rsp_t s_rsp
);
  typedef enum logic [2:0] {IDLE, PASS, A_RD, RMW_RD, RMW_WR} state_t;
  state_t      state_q, state_d;
  bus_req_t    s_req_q;
  bus_rsp_t    m_rsp_q;
  logic        lock_q;
  logic [4:0]  bit_q;
  logic        bit_val_q;
  logic        busy_q;

  // Window decode
  // Both windows are 32 MB spans; the top seven address bits pick one
  wire logic in_sram = (m_req.addr & `ALIAS_SPAN_MASK) == `SRAM_ALIAS_BASE; // R1
  wire logic in_peri = (m_req.addr & `ALIAS_SPAN_MASK) == `PERI_ALIAS_BASE; // R2
  wire logic is_alias = in_sram | in_peri;
  wire logic [31:0] region_base = in_sram ? `SRAM_REGION_BASE
                                          : `PERI_REGION_BASE;
  // Alias offset / 32 gives byte offset; word-aligned, bit from [6:2]
  wire logic [17:0] word_idx =
    m_req.addr[`ALIAS_OFS_MSB:`ALIAS_WORD_LSB]; // R3 R4 R6
  wire logic [31:0] region_addr = region_base | {12'h000, word_idx, 2'h0};
  wire logic [4:0]  bit_sel = m_req.addr[6:`ALIAS_BIT_LSB]; // R5 R6
  // A request during the answer pulse is dropped, so one access is in flight
  wire logic        take = (state_q == IDLE) && !busy_q && m_req.valid; // R9
  // Final slave answer of an access; the master answer follows it
  wire logic        rsp_fire = s_rsp.valid && (state_q == PASS
                               || state_q == A_RD || state_q == RMW_WR);
  wire logic [31:0] rd_bit = {31'h0000_0000, s_rsp.rdata[bit_q]}; // R7
  wire logic [31:0] set_mask = 32'h0000_0001 << bit_q;
  wire logic [31:0] mod_word = bit_val_q ? (s_rsp.rdata | set_mask)
                                         : (s_rsp.rdata & ~set_mask); // R8

  // Sequencer: the write leg of an alias write never leaves the locked
  // pair of states, so no other master slips in between read and write
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (take) begin
          if (!is_alias) state_d = PASS; // R10
          else if (m_req.write) state_d = RMW_RD;
          else state_d = A_RD;
        end
      end
      PASS:   if (s_rsp.valid) state_d = IDLE;
      A_RD:   if (s_rsp.valid) state_d = IDLE;
      RMW_RD: if (s_rsp.valid) state_d = RMW_WR;
      RMW_WR: if (s_rsp.valid) state_d = IDLE;
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= IDLE;
      s_req_q   <= '0;
      m_rsp_q   <= '0;
      lock_q    <= 1'b0;
      bit_q     <= 5'h00;
      bit_val_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      busy_q        <= (state_d != IDLE) || rsp_fire;
      s_req_q.valid <= 1'b0;
      m_rsp_q       <= '0;
      if (take) begin
        s_req_q.valid <= 1'b1;
        bit_q         <= bit_sel;
        bit_val_q     <= m_req.wdata[0];
        if (!is_alias) begin
          s_req_q.write <= m_req.write; // R10
          s_req_q.addr  <= m_req.addr;
          s_req_q.wdata <= m_req.wdata;
        end else begin
          s_req_q.write <= 1'b0; // R6
          s_req_q.addr  <= region_addr;
          s_req_q.wdata <= 32'h0000_0000;
          lock_q        <= m_req.write; // R9
        end
      end
      if (s_rsp.valid) begin
        case (state_q)
          PASS:   m_rsp_q <= s_rsp;
          A_RD:   m_rsp_q <= '{valid: 1'b1, rdata: rd_bit}; // R7
          RMW_RD: begin
            s_req_q.valid <= 1'b1; // R8
            s_req_q.write <= 1'b1;
            s_req_q.wdata <= mod_word;
          end
          RMW_WR: begin
            lock_q  <= 1'b0;
            m_rsp_q <= '{valid: 1'b1, rdata: 32'h0000_0000};
          end
          default: ;
        endcase
      end
    end
  end

  assign s_req  = s_req_q;
  assign m_rsp  = m_rsp_q;
  assign s_lock = lock_q;
  assign m_busy = busy_q;

  // Checks of the access sequencing

  sequence rmw_read_done;
    state_q == RMW_RD && s_rsp.valid;
  endsequence
  sequence rmw_write_issued;
    s_req.valid && s_req.write && s_lock;
  endsequence
  sequence alias_read_done;
    state_q == A_RD && s_rsp.valid;
  endsequence
  sequence rmw_write_done;
    state_q == RMW_WR && s_rsp.valid;
  endsequence
  sequence pass_done;
    state_q == PASS && s_rsp.valid;
  endsequence

  rmw_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rmw_read_done |=> rmw_write_issued) // R8
    else $error("alias write did not follow read");
  lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == RMW_WR) |-> s_lock) // R9
    else $error("lock dropped during read-modify-write");
  lock_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && is_alias && m_req.write) |=> s_lock && s_req.valid
      && !s_req.write) // R9
    else $error("alias write did not lock before read");
  rd_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == A_RD && s_rsp.valid) |=>
      m_rsp.valid && m_rsp.rdata == {31'h0, $past(s_rsp.rdata[bit_q])})
    // R7
    else $error("alias read returned wrong bit");
  one_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rmw_write_issued |-> ((s_req.wdata ^ $past(s_rsp.rdata))
      & ~(32'h1 << bit_q)) == 32'h0) // R8
    else $error("alias write changed other bits");
  sram_xlat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && in_sram) |=> s_req.addr == ((`SRAM_REGION_BASE
      + (($past(m_req.addr) - `SRAM_ALIAS_BASE) >> 5)) & ~32'h3)) // R3
    else $error("SRAM alias translated wrongly");
  peri_xlat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && in_peri) |=> s_req.addr == ((`PERI_REGION_BASE
      + (($past(m_req.addr) - `PERI_ALIAS_BASE) >> 5)) & ~32'h3)) // R4
    else $error("peripheral alias translated wrongly");
  pass_thru_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && !is_alias) |=> s_req.valid && s_req.addr == $past(m_req.addr)
      && s_req.write == $past(m_req.write) && !s_lock) // R10
    else $error("pass-through access altered");
  // Busy rises as soon as an access is taken
  busy_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    take |=> m_busy)
    else $error("busy did not rise after take");
  // A request during the answer pulse starts nothing
  refuse_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (state_q == IDLE && m_busy && m_req.valid) |=> !s_req.valid)
    else $error("request taken while busy");
  // With no request taken the slave side stays quiet
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (state_q == IDLE && !take) |=> !s_req.valid)
    else $error("slave request without master request");
  // The lock never outlives an access
  lock_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (state_q == IDLE) |-> !s_lock)
    else $error("lock held while idle");
  // The master answer is a single-cycle pulse
  rsp_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    m_rsp.valid |=> !m_rsp.valid)
    else $error("answer pulse longer than one cycle");
  // Only the lowest bit of an alias read answer may be set
  rd_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    alias_read_done |=> m_rsp.valid && m_rsp.rdata[31:1] == 31'h0)
    else $error("alias read upper bits not zero");
  // The alias write ends with a zero answer and a free bus
  wr_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    rmw_write_done |=> m_rsp.valid && m_rsp.rdata == 32'h0 && !s_lock)
    else $error("alias write answer wrong");
  // A passed access hands the slave data back untouched
  pass_rsp_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    pass_done |=> m_rsp.valid && m_rsp.rdata == $past(s_rsp.rdata))
    else $error("pass-through answer altered");
  // The written bit carries the value of the master's bit 0
  set_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    rmw_write_issued |-> s_req.wdata[bit_q] == bit_val_q)
    else $error("alias write set wrong value");
  // An alias read is a plain unlocked read of the region word
  alias_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    (take && is_alias && !m_req.write) |=> s_req.valid && !s_req.write
      && !s_lock)
    else $error("alias read issued wrongly");
  // Busy covers the answer pulse and falls right after it
  busy_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    rmw_write_done |=> m_busy ##1 !m_busy)
    else $error("busy did not end after write");
endmodule

// ---- sim/slave_mem_model.sv ----
// Purpose: Slave memory model behind the bit alias translator.
// Assumes: One request at a time; dly+1 idle cycles come before the answer.
// Notes:   Unwritten words read as the inverse of their address.
`timescale 1ns/1ps
module slave_mem_model
  import bit_alias_pkg::*;
(
  // Clock and delay
  input  wire logic       clk_sys,
  input  wire logic [1:0] dly,
  // Bus
  input  wire bus_req_t   s_req,
  output bus_rsp_t        s_rsp
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] hold_q;
  int          cnt_q = -1;
  initial s_rsp = '0;
  always @(posedge clk_sys) begin
    s_rsp.valid <= 1'b0;
    // Idle data toggles so stale values never look valid
    s_rsp.rdata <= ~s_rsp.rdata;
    if (s_req.valid) begin
      hold_q <= s_req.write ? 32'h0 :
                mem.exists(s_req.addr) ? mem[s_req.addr] : ~s_req.addr;
      if (s_req.write) mem[s_req.addr] = s_req.wdata;
      cnt_q <= dly;
    end else if (cnt_q == 0) begin
      s_rsp <= '{1'b1, hold_q};
      cnt_q <= -1;
    end else if (cnt_q > 0) cnt_q <= cnt_q - 1;
  end
endmodule

// ---- sim/bit_alias_translator_tb.sv ----
// Purpose: Random and corner checks of the bit alias translator.
// Assumes: Slave model answers after 1..4 idle cycles.
// Notes:   A shadow memory predicts every answer.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module bit_alias_translator_tb
  import bit_alias_pkg::*;
;
  logic        clk_sys = 0, rst_n = 0, m_busy, s_lock, lock_seen;
  logic [1:0]  dly = 0;
  logic [31:0] rs = 32'h2F78, a, last_addr, shadow [logic [31:0]];
  bus_req_t    m_req = '0, s_req;
  bus_rsp_t    m_rsp, s_rsp;
  int          fail_count = 0, tests_run = 0;
  logic [31:0] corners [6] = '{32'h2200_0000, 32'h23FF_FFFC, 32'h4200_007C,
                               32'h43FF_FFFC, 32'h21FF_FFFC, 32'h4400_0000};
  always #25 clk_sys = ~clk_sys;
  bit_alias_translator u_bit_alias_translator (.clk_sys(clk_sys),
    .rst_n(rst_n), .m_req(m_req), .m_rsp(m_rsp), .m_busy(m_busy),
    .s_req(s_req), .s_lock(s_lock), .s_rsp(s_rsp));
  slave_mem_model u_slave_mem_model (.clk_sys(clk_sys), .dly(dly),
    .s_req(s_req), .s_rsp(s_rsp));
  always @(negedge clk_sys) if (s_req.valid) begin
    last_addr <= s_req.addr;
    lock_seen <= s_lock;
  end
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic go(input logic wr, input logic [31:0] ad, wd);
    logic        al;
    logic [31:0] tgt, old, exp;
    al  = (ad[31:25] == 7'h11) || (ad[31:25] == 7'h21);
    tgt = al ? {ad[31:25] - 7'h01, 5'h0, ad[24:7], 2'b00} : ad;
    old = shadow.exists(tgt) ? shadow[tgt] : ~tgt;
    exp = wr ? 32'h0 : al ? {31'h0, old[ad[6:2]]} : old;
    if (wr) begin
      if (al) old[ad[6:2]] = wd[0];
      else old = wd;
      shadow[tgt] = old;
    end
    dly   <= rs[1:0];
    m_req <= '{1'b1, wr, ad, wd};
    @(posedge clk_sys);
    m_req.valid <= 1'b0;
    repeat (60) begin
      @(negedge clk_sys);
      if (m_rsp.valid === 1'b1) break;
    end
    `CHK(m_rsp.valid, 1'b1)
    `CHK(m_busy, 1'b1)
    `CHK(m_rsp.rdata, exp)
    `CHK(last_addr, tgt)
    `CHK(lock_seen, al & wr)
    @(posedge clk_sys);
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1ms;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (corners[i]) begin
      go(1'b1, corners[i], 32'h1);
      go(1'b0, corners[i], 32'h0);
    end
    repeat (300) begin
      void'(xs());
      a = {rs[3] ? 6'h10 : 6'h08, rs[2], 1'b0, 11'h0,
           rs[2] ? rs[14:4] : {5'h0, rs[9:4]}, 2'b00};
      go(rs[0], a, xs());
    end
    give_verdict();
  end
endmodule
